// ### dv/isrp_host_model.sv
// host side of the record read port: one word read per call
// assumes the answer arrives one clock after the request, as the read port promises
`timescale 1ns/10ps
`default_nettype none
module isrp_host_model
(
  input  wire logic        clk,        // system clock
  input  wire logic        rd_valid,   // answer strobe
  input  wire logic [31:0] rd_data,    // answered word
  output var  logic        rd_req,     // read pulse
  output var  logic [6:0]  rd_offset   // record byte offset
);
  initial
  begin
    rd_req    = 1'b0;
    rd_offset = 7'h00;
  end

  // ok stays low when no answer came in the fixed latency
  task automatic read(input logic [6:0] ofs, output logic [31:0] data, output logic ok);
    @(posedge clk);
    #1;
    rd_req    = 1'b1;
    rd_offset = ofs;
    @(posedge clk);
    #1;
    ok        = rd_valid;
    data      = rd_data;
    rd_req    = 1'b0;
    // released offset shows a changed pattern, never the old value
    rd_offset = ~ofs;
  endtask : read
endmodule : isrp_host_model
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the record packer
// assumes the host model in dv/ and a shortened filter loop limit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import isrp_pkg::*;
  localparam int LIM = 20;
  logic clk, reset, sol_valid, loop_start, gnss_fix_flag, inertial_link_fault, mag_pres_fault;
  logic gnss_link_fault, restore_pin, restore_cmd, set_wr, set_port, rd_req, rd_valid, restore_done, ok;
  logic [1:0]  filter_mode;
  logic [31:0] down_velocity, attitude_sigma, position_sigma, velocity_sigma, rd_data, word;
  logic [BAUD_W-1:0] set_baud;
  logic [RATE_W-1:0] set_async_hz;
  logic [7:0]  set_async_type;
  logic [6:0]  rd_offset;
  logic [15:0] filter_status_word, st;
  logic [NUM_PORTS-1:0][BAUD_W-1:0] baud_rate;
  logic [NUM_PORTS-1:0][RATE_W-1:0] async_hz;
  logic [NUM_PORTS-1:0][7:0]        async_type;
  int error_cnt   = 0;
  int comparisons = 0;

  isrp_top #(.LOOP_LIMIT_CYCLES(LIM)) DUT (.clk, .reset, .sol_valid, .filter_mode, .down_velocity,
    .attitude_sigma, .position_sigma, .velocity_sigma, .loop_start, .gnss_fix_flag, .inertial_link_fault,
    .mag_pres_fault, .gnss_link_fault, .restore_pin, .restore_cmd, .set_wr, .set_port, .set_baud,
    .set_async_hz, .set_async_type, .rd_req, .rd_offset, .rd_data, .rd_valid, .filter_status_word,
    .baud_rate, .async_hz, .async_type, .restore_done);
  isrp_host_model HOST (.clk, .rd_valid, .rd_data, .rd_req, .rd_offset);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [15:0] exp_st(logic [1:0] m, logic fx, logic [3:0] e);
    return {9'h000, e, fx, m};
  endfunction : exp_st

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rd(logic [6:0] ofs, logic [31:0] exp);
    HOST.read(ofs, word, ok);
    chk("read strobe", 32'h0000_0001, {31'h0, ok});
    chk("record word", exp, word);
  endtask : rd

  task automatic chk_factory();
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      chk("baud", 32'(FACTORY_BAUD), 32'(baud_rate[p]));
      chk("rate", 32'(FACTORY_ASYNC_HZ), 32'(async_hz[p]));
      chk("type", 32'(ASYNC_INS_SOLUTION), 32'(async_type[p]));
    end
  endtask : chk_factory

  task automatic end_sim();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    {sol_valid, loop_start, gnss_fix_flag, inertial_link_fault, mag_pres_fault, gnss_link_fault} = '0;
    {restore_pin, restore_cmd, set_wr, set_port, filter_mode, set_baud, set_async_hz, set_async_type} = '0;
    {down_velocity, attitude_sigma, position_sigma, velocity_sigma} = '0;
    reset = 1'b1;
    void'($urandom(32'h58e1));
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    chk_factory();
    chk("status", 32'h0000_0000, 32'(filter_status_word));
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      #1;
      filter_mode = 2'(i % 3);
      {gnss_link_fault, mag_pres_fault, inertial_link_fault, gnss_fix_flag} = (i == 3) ? 4'hf : 4'($urandom);
      st = exp_st(filter_mode, gnss_fix_flag, {gnss_link_fault, mag_pres_fault, inertial_link_fault, 1'b0});
      repeat (5) @(posedge clk);
      #1;
      chk("status", 32'(st), 32'(filter_status_word));
      if (i < 3)
        continue;
      // new solution while status is steady, so the snapshot is known
      {down_velocity, attitude_sigma} = {$urandom, $urandom};
      {position_sigma, velocity_sigma} = {$urandom, $urandom};
      sol_valid = 1'b1;
      @(posedge clk);
      #1 sol_valid = 1'b0;
      repeat (7) @(posedge clk);
      rd(7'd56, down_velocity);
      rd(7'd61, attitude_sigma);
      rd(7'd64, position_sigma);
      rd(7'd68, velocity_sigma);
      rd(7'd10, {st, 16'h0000});
    end
    rd(7'd72, 32'h0000_0000);
    rd(7'd127, 32'h0000_0000);
    // loop restarted well inside the limit, then left to overrun
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      #1 loop_start = 1'b1;
      @(posedge clk);
      #1 loop_start = 1'b0;
      repeat (8) @(posedge clk);
    end
    #1 chk("loop bit", 32'h0000_0000, 32'(filter_status_word[ERR_LSB]));
    repeat (LIM + 4) @(posedge clk);
    #1 chk("loop bit", 32'h0000_0001, 32'(filter_status_word[ERR_LSB]));
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      #1;
      {set_wr, set_port, set_baud, set_async_hz, set_async_type} = {1'b1, 1'($urandom), 20'($urandom), 16'($urandom)};
      @(posedge clk);
      #1 set_wr = 1'b0;
      chk("set baud", 32'(set_baud), 32'(baud_rate[set_port]));
      chk("set rate", 32'(set_async_hz), 32'(async_hz[set_port]));
      chk("set type", 32'(set_async_type), 32'(async_type[set_port]));
      if (k == 0)
      begin
        restore_cmd = 1'b1;
        @(posedge clk);
        #1 restore_cmd = 1'b0;
        chk("restore done", 32'h0000_0001, 32'(restore_done));
      end
      else
      begin
        // pin passes two sync stages and an edge detector before it acts
        restore_pin = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("restore done", 32'h0000_0001, 32'(restore_done));
        repeat (3) @(posedge clk);
        #1 restore_pin = 1'b0;
      end
      chk_factory();
    end
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// ### logic/isrp_pkg.sv
// solution record packer: shared constants, field layout and types
// assumes a single 10 MHz clock and a record made of 32-bit little-endian words
package isrp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 100;
  localparam int LOOP_MAX_MS     = 5;
  localparam int LOOP_MAX_CYCLES = LOOP_MAX_MS * 1_000_000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // record layout, byte offsets
  // ----------------------------------------------------------------
  localparam int REC_BYTES      = 72;
  localparam int REC_WORDS      = REC_BYTES / 4;
  localparam int REC_ADDR_W     = 5;
  localparam int OFS_STATUS     = 10;
  localparam int OFS_DOWN_VEL   = 56;
  localparam int OFS_ATT_SIGMA  = 60;
  localparam int OFS_POS_SIGMA  = 64;
  localparam int OFS_VEL_SIGMA  = 68;
  localparam int STATUS_SHIFT   = 8 * (OFS_STATUS % 4);

  localparam logic [REC_ADDR_W-1:0] W_STATUS    = REC_ADDR_W'(OFS_STATUS / 4);
  localparam logic [REC_ADDR_W-1:0] W_DOWN_VEL  = REC_ADDR_W'(OFS_DOWN_VEL / 4);
  localparam logic [REC_ADDR_W-1:0] W_ATT_SIGMA = REC_ADDR_W'(OFS_ATT_SIGMA / 4);
  localparam logic [REC_ADDR_W-1:0] W_POS_SIGMA = REC_ADDR_W'(OFS_POS_SIGMA / 4);
  localparam logic [REC_ADDR_W-1:0] W_VEL_SIGMA = REC_ADDR_W'(OFS_VEL_SIGMA / 4);
  localparam logic [3:0]            BE_WORD     = 4'h000f;
  localparam logic [3:0]            BE_STATUS   = 4'(4'h0003 << (OFS_STATUS % 4));

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int MODE_LSB      = 0;
  localparam int MODE_W        = 2;
  localparam int FIX_BIT       = 2;
  localparam int ERR_LSB       = 3;
  localparam int ERR_W         = 4;
  localparam int RSVD_LSB      = 7;
  localparam int RSVD_W        = 9;
  localparam int ERR_LOOP_TIME = 0;
  localparam int ERR_INERTIAL  = 1;
  localparam int ERR_MAG_PRES  = 2;
  localparam int ERR_GNSS      = 3;

  typedef enum logic [1:0] {
    MODE_NOT_TRACKING = 2'b00,
    MODE_OUT_OF_SPEC  = 2'b01,
    MODE_TRACKING     = 2'b10
  } isrp_mode_e;

  // ----------------------------------------------------------------
  // serial port settings and factory values
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 2;
  localparam int BAUD_W    = 20;
  localparam int RATE_W    = 8;
  localparam logic [BAUD_W-1:0] FACTORY_BAUD     = BAUD_W'(115200);
  localparam logic [RATE_W-1:0] FACTORY_ASYNC_HZ = RATE_W'(40);

  // output type codes are arbitrary local encodings
  typedef enum logic [7:0] {
    ASYNC_OFF          = 8'h00,
    ASYNC_INS_SOLUTION = 8'h01
  } isrp_async_e;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_WRITE = 2'b01
  } isrp_seq_e;

endpackage : isrp_pkg

// ### logic/isrp_rec_if.sv
// record store port: word writes with byte enables, registered word reads
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface isrp_rec_if;
  import isrp_pkg::*;
  logic                  wr_en;
  logic [REC_ADDR_W-1:0] wr_addr;
  logic [3:0]            wr_be;
  logic [31:0]           wr_data;
  logic                  rd_en;
  logic [REC_ADDR_W-1:0] rd_addr;
  logic [31:0]           rd_data;
  modport writer (output wr_en, output wr_addr, output wr_be, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
  modport store  (input wr_en, input wr_addr, input wr_be, input wr_data,
                  input rd_en, input rd_addr, output rd_data);
endinterface : isrp_rec_if
`default_nettype wire

// ### logic/isrp_rec_mem.sv
// record word store with byte-lane writes and registered read data
// assumes a synchronous active-high reset; addresses past the end read zero
`timescale 1ns/10ps
`default_nettype none
module isrp_rec_mem
  import isrp_pkg::*;
#(
  parameter int DEPTH = REC_WORDS
)(
  input wire logic clk,    // system clock
  input wire logic reset,  // synchronous reset, active high
  isrp_rec_if.store rec    // write and read port
);

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0]            rdata;
  } isrp_mem_s;

  isrp_mem_s st;
  isrp_mem_s next_st;

  always_comb
  begin
    next_st = st;
    if (rec.wr_en && (32'(rec.wr_addr) < DEPTH))
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (rec.wr_be[b])
          next_st.mem[rec.wr_addr][8*b +: 8] = rec.wr_data[8*b +: 8];
      end
    end
    if (rec.rd_en)
      next_st.rdata = (32'(rec.rd_addr) < DEPTH) ? st.mem[rec.rd_addr] : 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign rec.rd_data = st.rdata;

endmodule : isrp_rec_mem
`default_nettype wire

// ### logic/isrp_top.sv
// solution record packer: last record fields, filter status word, factory defaults
// assumes one 10 MHz clock; fault and fix inputs are pins from other domains
//
// Contract
// - down velocity float goes to record byte 56
// - attitude uncertainty float goes to record byte 60
// - position uncertainty float goes to record byte 64
// - velocity uncertainty float goes to record byte 68, the last field
// - status bits 1:0 carry filter mode: 0 no track, 1 out of spec, 2 tracking
// - status bit 2 is high while the satellite receiver has a proper fix
// - status bits 6:3 hold sensor error flags, all zero when no fault
// - status bits 15:7 are reserved with no meaning
// - error bit 0 is set when a filter loop lasts longer than 5 ms
// - error bit 1 is set on an inertial unit link fault
// - error bit 2 is set on a magnetometer or pressure sensor fault
// - error bit 3 is set on a satellite receiver link fault
// - factory restore sets both serial ports to 115200 baud
// - factory restore sets unsolicited output to 40 Hz on both ports
// - factory restore selects the solution record as unsolicited output type
// - restore command or restore pin returns all settings to factory values
// - status word is a 2-byte field at record byte 10
`timescale 1ns/10ps
`default_nettype none
module isrp_top
  import isrp_pkg::*;
#(
  parameter int LOOP_LIMIT_CYCLES = LOOP_MAX_CYCLES
)(
  input  wire logic                                clk,                     // 10 MHz clock
  input  wire logic                                reset,                   // synchronous, active high
  input  wire logic                                sol_valid,               // new solution, one-cycle pulse
  input  wire logic [MODE_W-1:0]                   filter_mode,             // filter mode code
  input  wire logic [31:0]                         down_velocity,           // float, m/s
  input  wire logic [31:0]                         attitude_sigma,          // float, deg
  input  wire logic [31:0]                         position_sigma,          // float, m
  input  wire logic [31:0]                         velocity_sigma,          // float, m/s
  input  wire logic                                loop_start,              // filter loop start pulse
  input  wire logic                                gnss_fix_flag,           // pin: receiver has fix
  input  wire logic                                inertial_link_fault,     // pin: inertial link fault
  input  wire logic                                mag_pres_fault,          // pin: mag/pressure fault
  input  wire logic                                gnss_link_fault,         // pin: receiver link fault
  input  wire logic                                restore_pin,             // pin: factory restore
  input  wire logic                                restore_cmd,             // restore command pulse
  input  wire logic                                set_wr,                  // settings write pulse
  input  wire logic                                set_port,                // serial port index
  input  wire logic [BAUD_W-1:0]                   set_baud,                // baud rate
  input  wire logic [RATE_W-1:0]                   set_async_hz,            // output rate, Hz
  input  wire logic [7:0]                          set_async_type,          // output type code
  input  wire logic                                rd_req,                  // record read pulse
  input  wire logic [6:0]                          rd_offset,               // record byte offset
  output logic [31:0]                              rd_data,                 // record word
  output logic                                     rd_valid,                // read answer pulse
  output logic [15:0]                              filter_status_word,      // live status word
  output logic [NUM_PORTS-1:0][BAUD_W-1:0]         baud_rate,               // per-port baud
  output logic [NUM_PORTS-1:0][RATE_W-1:0]         async_hz,                // per-port output rate
  output logic [NUM_PORTS-1:0][7:0]                async_type,              // per-port output type
  output logic                                     restore_done             // restore applied pulse
);

  localparam int CW = $clog2(LOOP_LIMIT_CYCLES + 2);
  localparam logic [CW-1:0] LOOP_LIMIT = CW'(LOOP_LIMIT_CYCLES);
  localparam int PIN_FIX     = 0;
  localparam int PIN_INER    = 1;
  localparam int PIN_MAG     = 2;
  localparam int PIN_GNSS    = 3;
  localparam int PIN_RESTORE = 4;
  localparam logic [2:0] IDX_LAST = 3'h0004;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic        restore_d;
    logic        running;
    logic [CW-1:0] cnt;
    logic        loop_err;
    logic [15:0] status;
    logic [15:0] snap_status;
    logic [31:0] snap_down;
    logic [31:0] snap_att;
    logic [31:0] snap_pos;
    logic [31:0] snap_vel;
    isrp_seq_e   seq;
    logic [2:0]  idx;
    logic        wr_en;
    logic [REC_ADDR_W-1:0] wr_addr;
    logic [3:0]  wr_be;
    logic [31:0] wr_data;
    logic        rd_valid;
    logic [NUM_PORTS-1:0][BAUD_W-1:0] baud;
    logic [NUM_PORTS-1:0][RATE_W-1:0] hz;
    logic [NUM_PORTS-1:0][7:0]        typ;
    logic        restore_done;
  } isrp_top_s;

  isrp_top_s st;
  isrp_top_s next_st;
  logic      restore_req;

  isrp_rec_if rec_if ();

  // restore pin acts on its rising edge so a held pin does not lock the settings
  assign restore_req = restore_cmd || (st.s2[PIN_RESTORE] && !st.restore_d);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.s1 = {restore_pin, gnss_link_fault, mag_pres_fault, inertial_link_fault, gnss_fix_flag};
    next_st.s2 = st.s1;
    next_st.restore_d = st.s2[PIN_RESTORE];

    // loop timer saturates so a stalled filter keeps the flag up
    if (st.running && (st.cnt != LOOP_LIMIT))
      next_st.cnt = CW'(st.cnt + 1'b1);
    if (loop_start)
    begin
      if (st.cnt < LOOP_LIMIT)
        next_st.loop_err = 1'b0;
      next_st.cnt = '0;
      next_st.running = 1'b1;
    end
    if (st.running && (st.cnt == LOOP_LIMIT))
      next_st.loop_err = 1'b1;

    next_st.status = 16'h0000;
    next_st.status[MODE_LSB +: MODE_W] = filter_mode;
    next_st.status[FIX_BIT] = st.s2[PIN_FIX];
    next_st.status[ERR_LSB + ERR_LOOP_TIME] = st.loop_err;
    next_st.status[ERR_LSB + ERR_INERTIAL] = st.s2[PIN_INER];
    next_st.status[ERR_LSB + ERR_MAG_PRES] = st.s2[PIN_MAG];
    next_st.status[ERR_LSB + ERR_GNSS] = st.s2[PIN_GNSS];

    // record writer: status half-word, then the four trailing floats
    next_st.wr_en = 1'b0;
    case (st.seq)
      SEQ_WRITE:
      begin
        next_st.wr_en = 1'b1;
        next_st.wr_be = BE_WORD;
        case (st.idx)
          3'h0000:
          begin
            next_st.wr_addr = W_STATUS;
            next_st.wr_be = BE_STATUS;
            next_st.wr_data = {16'h0000, st.snap_status} << STATUS_SHIFT;
          end
          3'h0001:
          begin
            next_st.wr_addr = W_DOWN_VEL;
            next_st.wr_data = st.snap_down;
          end
          3'h0002:
          begin
            next_st.wr_addr = W_ATT_SIGMA;
            next_st.wr_data = st.snap_att;
          end
          3'h0003:
          begin
            next_st.wr_addr = W_POS_SIGMA;
            next_st.wr_data = st.snap_pos;
          end
          default:
          begin
            next_st.wr_addr = W_VEL_SIGMA;
            next_st.wr_data = st.snap_vel;
          end
        endcase
        next_st.idx = 3'(st.idx + 1'b1);
        if (st.idx == IDX_LAST)
          next_st.seq = SEQ_IDLE;
      end
      default:
        next_st.seq = SEQ_IDLE;
    endcase

    // a new solution restarts the writer so a finished write pass never mixes two epochs
    if (sol_valid)
    begin
      next_st.snap_status = st.status;
      next_st.snap_down = down_velocity;
      next_st.snap_att = attitude_sigma;
      next_st.snap_pos = position_sigma;
      next_st.snap_vel = velocity_sigma;
      next_st.seq = SEQ_WRITE;
      next_st.idx = 3'h0000;
    end

    next_st.rd_valid = rd_req;

    if (set_wr)
    begin
      next_st.baud[set_port] = set_baud;
      next_st.hz[set_port] = set_async_hz;
      next_st.typ[set_port] = set_async_type;
    end
    // restore overrides a same-cycle settings write
    next_st.restore_done = restore_req;
    if (restore_req)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        next_st.baud[p] = FACTORY_BAUD;
        next_st.hz[p] = FACTORY_ASYNC_HZ;
        next_st.typ[p] = ASYNC_INS_SOLUTION;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.seq <= SEQ_IDLE;
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        st.baud[p] <= FACTORY_BAUD;
        st.hz[p] <= FACTORY_ASYNC_HZ;
        st.typ[p] <= ASYNC_INS_SOLUTION;
      end
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // record store and outputs
  // ----------------------------------------------------------------
  assign rec_if.wr_en   = st.wr_en;
  assign rec_if.wr_addr = st.wr_addr;
  assign rec_if.wr_be   = st.wr_be;
  assign rec_if.wr_data = st.wr_data;
  assign rec_if.rd_en   = rd_req;
  assign rec_if.rd_addr = rd_offset[6:2];

  isrp_rec_mem #(
    .DEPTH (REC_WORDS)
  ) u_mem (
    .clk   (clk),
    .reset (reset),
    .rec   (rec_if.store)
  );

  assign rd_data            = rec_if.rd_data;
  assign rd_valid           = st.rd_valid;
  assign filter_status_word = st.status;
  assign baud_rate          = st.baud;
  assign async_hz           = st.hz;
  assign async_type         = st.typ;
  assign restore_done       = st.restore_done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rsvd_zero_a: assert property (@(posedge clk) disable iff (reset)
    filter_status_word[RSVD_LSB +: RSVD_W] == 9'h0000)
    else $error("reserved status bits not zero");
  mode_copy_a: assert property (@(posedge clk) disable iff (reset)
    sol_valid ##1 1'b1 |-> ##1 (rec_if.wr_en && rec_if.wr_data[STATUS_SHIFT +: MODE_W] == $past(filter_mode, 3)))
    else $error("mode field not written from filter mode");
  fix_path_a: assert property (@(posedge clk) disable iff (reset)
    gnss_fix_flag[*3] |=> filter_status_word[FIX_BIT])
    else $error("fix bit missing after fix pin held");
  err_clear_a: assert property (@(posedge clk) disable iff (reset)
    (!inertial_link_fault && !mag_pres_fault && !gnss_link_fault && !st.loop_err)[*3]
    |=> filter_status_word[ERR_LSB +: ERR_W] == 4'h0000)
    else $error("error field not zero without faults");
  loop_time_a: assert property (@(posedge clk) disable iff (reset)
    st.running && st.cnt == LOOP_LIMIT |-> ##2 filter_status_word[ERR_LSB + ERR_LOOP_TIME])
    else $error("loop overrun not flagged");
  inertial_err_a: assert property (@(posedge clk) disable iff (reset)
    inertial_link_fault[*3] |=> filter_status_word[ERR_LSB + ERR_INERTIAL])
    else $error("inertial fault not flagged");
  magpres_err_a: assert property (@(posedge clk) disable iff (reset)
    mag_pres_fault[*3] |=> filter_status_word[ERR_LSB + ERR_MAG_PRES])
    else $error("mag or pressure fault not flagged");
  gnss_err_a: assert property (@(posedge clk) disable iff (reset)
    gnss_link_fault[*3] |=> filter_status_word[ERR_LSB + ERR_GNSS])
    else $error("receiver link fault not flagged");
  down_word_a: assert property (@(posedge clk) disable iff (reset)
    sol_valid ##1 (!sol_valid)[*2] |=> rec_if.wr_addr == W_DOWN_VEL && rec_if.wr_data == $past(down_velocity, 3))
    else $error("down velocity not written at its word");
  att_word_a: assert property (@(posedge clk) disable iff (reset)
    sol_valid ##1 (!sol_valid)[*3] |=> rec_if.wr_addr == W_ATT_SIGMA && rec_if.wr_data == $past(attitude_sigma, 4))
    else $error("attitude sigma not written at its word");
  pos_word_a: assert property (@(posedge clk) disable iff (reset)
    sol_valid ##1 (!sol_valid)[*4] |=> rec_if.wr_addr == W_POS_SIGMA && rec_if.wr_data == $past(position_sigma, 5))
    else $error("position sigma not written at its word");
  vel_word_a: assert property (@(posedge clk) disable iff (reset)
    sol_valid ##1 (!sol_valid)[*5] |=> rec_if.wr_addr == W_VEL_SIGMA && rec_if.wr_en ##1 !rec_if.wr_en)
    else $error("velocity sigma not last write");
  status_lane_a: assert property (@(posedge clk) disable iff (reset)
    rec_if.wr_en && rec_if.wr_addr == W_STATUS |-> rec_if.wr_be == BE_STATUS)
    else $error("status word written on wrong lanes");
  restore_baud_a: assert property (@(posedge clk) disable iff (reset)
    restore_cmd |=> baud_rate[0] == FACTORY_BAUD && baud_rate[1] == FACTORY_BAUD && restore_done)
    else $error("baud not restored");
  restore_rate_a: assert property (@(posedge clk) disable iff (reset)
    restore_cmd |=> async_hz[0] == FACTORY_ASYNC_HZ && async_hz[1] == FACTORY_ASYNC_HZ)
    else $error("output rate not restored");
  restore_pin_a: assert property (@(posedge clk) disable iff (reset)
    !restore_pin ##1 restore_pin |-> ##3 (async_type[0] == ASYNC_INS_SOLUTION && async_type[1] == ASYNC_INS_SOLUTION))
    else $error("restore pin did not select solution output");

endmodule : isrp_top
`default_nettype wire
